/* File: rtl/pms_defs.svh */
/*
  constants of the code-mode multichip sync block: register indexes, field
  positions, reset values and frame timing.
  assumes nothing; included by the package and by the design modules.
*/
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH
// register indexes, byte address is four times the index
`define PMS_IDX_CTRL     8'h01
`define PMS_IDX_CFG      8'h03
`define PMS_IDX_STAT     8'h09
`define PMS_IDX_MASK     8'h0A
// control register fields
`define PMS_CTRL_CODE    13
`define PMS_CTRL_MODE    12
`define PMS_CTRL_PULSE   11
`define PMS_CTRL_WMASK   32'h0000_3800
`define PMS_CTRL_RST     32'h0000_0000
// configuration register fields
`define PMS_CFG_THR_HI   31
`define PMS_CFG_THR_LO   27
`define PMS_CFG_RXEN     26
`define PMS_CFG_TXEN     25
`define PMS_CFG_IDLY_HI  23
`define PMS_CFG_IDLY_LO  19
`define PMS_CFG_ODLY_HI  15
`define PMS_CFG_ODLY_LO  11
`define PMS_CFG_OPOL     9
`define PMS_CFG_CST_HI   7
`define PMS_CFG_CST_LO   4
`define PMS_CFG_WMASK    32'hFFF8_FEF0
`define PMS_CFG_RST      32'h8000_0400
// status register fields
`define PMS_STAT_DERR    5
`define PMS_STAT_SERR    6
`define PMS_STAT_LOCK    10
`define PMS_STAT_LOST    11
`define PMS_STAT_CLR     12
// mask register fields, one masks the flag
`define PMS_MASK_DERR    0
`define PMS_MASK_SERR    1
// code and frame
`define PMS_PN_WORD      32'hE6A1_3B59
`define PMS_FRAME_LAST   6'h3F
`define PMS_PHASE_LAST   6'h1F
`define PMS_THR_BASE     6'h10
`define PMS_RESP_OKAY    2'h0
`define PMS_RESP_SLVERR  2'h2
`endif

/* File: rtl/pms_pkg.sv */
/*
  types and helpers of the multichip sync block.
  assumes the constants header sits beside it.
*/
`default_nettype none
`include "pms_defs.svh"
package pms_pkg;
  typedef enum logic {st_search, st_track} pms_rx_state_t;
  typedef struct packed {
    logic [4:0] thresh;
    logic       rx_en;
    logic       tx_en;
    logic [4:0] in_dly;
    logic [4:0] out_dly;
    logic       out_half;
    logic [3:0] clk_state;
  } pms_cfg_t;
  // unpack the configuration word into its fields
  function automatic pms_cfg_t pms_cfg_f(input logic [31:0] r);
    pms_cfg_t c;
    c.thresh    = r[`PMS_CFG_THR_HI:`PMS_CFG_THR_LO];
    c.rx_en     = r[`PMS_CFG_RXEN];
    c.tx_en     = r[`PMS_CFG_TXEN];
    c.in_dly    = r[`PMS_CFG_IDLY_HI:`PMS_CFG_IDLY_LO];
    c.out_dly   = r[`PMS_CFG_ODLY_HI:`PMS_CFG_ODLY_LO];
    c.out_half  = r[`PMS_CFG_OPOL];
    c.clk_state = r[`PMS_CFG_CST_HI:`PMS_CFG_CST_LO];
    return c;
  endfunction
  // matching chips needed for a threshold: larger threshold, closer match
  function automatic logic [5:0] pms_need(input logic [4:0] thr);
    return `PMS_THR_BASE + {2'h0, thr[4:1]};
  endfunction
endpackage
`default_nettype wire

/* File: rtl/pms_pn_tx.sv */
/*
  frame generator of the sync code: 32 code chips then 32 phase bits.
  assumes en held steady for whole frames; phase_word sampled at frame start.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pms_defs.svh"
module pms_pn_tx import pms_pkg::*; (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        en,
  input  wire logic [31:0] phase_word,
  output logic             code_bit
);
  logic [5:0]  cnt_reg, cnt_next;
  logic [63:0] sh_reg, sh_next;
  logic        bit_reg, bit_next;

  // load a new frame at count zero, otherwise shift the next chip out
  always_comb begin
    logic [63:0] w;
    w        = (cnt_reg == 6'h00) ? {`PMS_PN_WORD, phase_word} : {sh_reg[62:0], 1'h0};
    cnt_next = en ? cnt_reg + 6'h01 : 6'h00;
    sh_next  = en ? w : 64'h0;
    bit_next = en ? w[63] : 1'h0;
  end

  // frame state registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 6'h00;
      sh_reg  <= 64'h0;
      bit_reg <= 1'h0;
    end else begin
      cnt_reg <= cnt_next;
      sh_reg  <= sh_next;
      bit_reg <= bit_next;
    end
  end

  assign code_bit = bit_reg;
endmodule
`default_nettype wire

/* File: rtl/pms_correlator.sv */
/*
  correlator: counts window chips that agree with the expected code.
  assumes the window holds the newest chip in bit 0.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pms_defs.svh"
module pms_correlator import pms_pkg::*; (
  input  wire logic [31:0] window,
  input  wire logic [4:0]  thresh,
  output logic             hit
);
  logic [31:0] agree;
  logic [5:0]  count;

  // population count of agreeing chips, compared with the needed count
  always_comb begin
    agree = ~(window ^ `PMS_PN_WORD);
    count = 6'h00;
    for (int i = 0; i < 32; i++) begin
      count = count + {5'h00, agree[i]};
    end
    hit = (count >= pms_need(thresh));
  end
endmodule
`default_nettype wire

/* File: rtl/pms_sync_top.sv */
/*
  code-mode multichip sync engine with timing-error interrupt, AXI4-Lite slave.
  assumes sync_in already sampled on clk_sys behind the analog input delay,
  the error inputs are one-cycle pulses from timing monitors, and the pin pad
  resolves the open-drain interrupt from irq_oe.
*/
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
// Behaviour
// - align clock state and oscillator phase everywhere
// - master drives output; all enable input
// - master sends the encoded sync frame
// - one alignment pulse per recognised code
// - threshold field sets required match, default 16
// - lock decided over many chips
// - lock status bit readable at bit 10
// - sticky lost bit, cleared by clear bit
// - output delay field steers transmit delay taps
// - polarity bit delays output half period
// - input delay field steers receive delay taps
// - interrupt open drain, active low, never high
// - two error flags raise interrupt, maskable
// - error flags latched until written
// - pulse loads programmed clock state
// - clock state machine runs 32 states
// - slaves load master phase from frame
`timescale 1ns/100ps
`default_nettype none
`include "pms_defs.svh"
module pms_sync_top import pms_pkg::*; (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sync_in,
  output logic             sync_out,
  output logic             sync_out_oe,
  output logic [4:0]       sync_out_dly,
  output logic             sync_out_half,
  output logic [4:0]       sync_in_dly,
  input  wire logic [31:0] nco_phase_in,
  output logic [31:0]      nco_phase_out,
  output logic             nco_load,
  output logic             align_pulse,
  output logic [4:0]       clk_gen_state,
  output logic             sync_lock,
  input  wire logic        data_timing_err,
  input  wire logic        sync_timing_err,
  output logic             irq_out,
  output logic             irq_oe
);
  // bus side state
  logic        aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [7:0]  aw_idx_reg, aw_idx_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        do_wr;
  // register file state
  logic [31:0] ctrl_reg, ctrl_next, cfg_reg, cfg_next;
  logic        clr_reg, clr_next;
  logic [1:0]  mask_reg, mask_next, err_reg, err_next;
  logic        irq_oe_reg, irq_oe_next;
  // receiver and clock state machine state
  pms_rx_state_t st_reg, st_next;
  logic [5:0]  fcnt_reg, fcnt_next;
  logic [31:0] win_reg, win_next, ph_reg, ph_next;
  logic        lock_reg, lock_next, lost_reg, lost_next;
  logic        align_reg, align_next, load_reg, load_next;
  logic [4:0]  csm_reg, csm_next;
  logic        tx_on_reg, tx_on_next;
  pms_cfg_t    cfg;
  logic        code_mode, rx_act, hit, tx_bit;

  // index is mapped when it names one of the four registers
  function automatic logic mapped(input logic [7:0] idx);
    return idx == `PMS_IDX_CTRL || idx == `PMS_IDX_CFG ||
           idx == `PMS_IDX_STAT || idx == `PMS_IDX_MASK;
  endfunction

  // byte-lane merge of a write into a register with writable bits wm
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb, input logic [31:0] wm);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wm;
    return (old & ~lanes) | (d & lanes);
  endfunction

  assign cfg       = pms_cfg_f(cfg_reg);
  assign code_mode = ctrl_reg[`PMS_CTRL_CODE] & ctrl_reg[`PMS_CTRL_MODE] &
                     ~ctrl_reg[`PMS_CTRL_PULSE];
  assign rx_act    = code_mode & cfg.rx_en;
  assign do_wr     = aw_hold_reg & w_hold_reg & ~bvalid_reg;

  // AXI4-Lite channels: address and data held apart, response after both
  always_comb begin
    aw_hold_next = aw_hold_reg;
    aw_idx_next  = aw_idx_reg;
    w_hold_next  = w_hold_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (s_axi_awvalid && !aw_hold_reg) begin
      aw_hold_next = 1'h1;
      aw_idx_next  = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && !w_hold_reg) begin
      w_hold_next = 1'h1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_hold_next = 1'h0;
      w_hold_next  = 1'h0;
      bvalid_next  = 1'h1;
      bresp_next   = mapped(aw_idx_reg) ? `PMS_RESP_OKAY : `PMS_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'h0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'h1;
      rresp_next  = mapped(s_axi_araddr[9:2]) ? `PMS_RESP_OKAY : `PMS_RESP_SLVERR;
      unique case (s_axi_araddr[9:2])
        `PMS_IDX_CTRL: rdata_next = ctrl_reg;
        `PMS_IDX_CFG:  rdata_next = cfg_reg;
        `PMS_IDX_STAT: begin
          rdata_next                 = 32'h0;
          rdata_next[`PMS_STAT_DERR] = err_reg[0];
          rdata_next[`PMS_STAT_SERR] = err_reg[1];
          rdata_next[`PMS_STAT_LOCK] = lock_reg;
          rdata_next[`PMS_STAT_LOST] = lost_reg;
          rdata_next[`PMS_STAT_CLR]  = clr_reg;
        end
        `PMS_IDX_MASK: rdata_next = {30'h0, mask_reg};
        default:       rdata_next = 32'h0;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'h0;
    end
  end

  // bus side registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold_reg <= 1'h0;
      aw_idx_reg  <= 8'h00;
      w_hold_reg  <= 1'h0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'h0;
      bresp_reg   <= 2'h0;
      rvalid_reg  <= 1'h0;
      rresp_reg   <= 2'h0;
      rdata_reg   <= 32'h0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      aw_idx_reg  <= aw_idx_next;
      w_hold_reg  <= w_hold_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  // register writes, latched error flags and the interrupt level
  always_comb begin
    logic wr_stat;
    logic [1:0] w1c;
    wr_stat     = do_wr && aw_idx_reg == `PMS_IDX_STAT;
    w1c         = 2'h0;
    ctrl_next   = ctrl_reg;
    cfg_next    = cfg_reg;
    clr_next    = clr_reg;
    mask_next   = mask_reg;
    if (do_wr && aw_idx_reg == `PMS_IDX_CTRL)
      ctrl_next = merge(ctrl_reg, wdata_reg, wstrb_reg, `PMS_CTRL_WMASK);
    if (do_wr && aw_idx_reg == `PMS_IDX_CFG)
      cfg_next = merge(cfg_reg, wdata_reg, wstrb_reg, `PMS_CFG_WMASK);
    if (do_wr && aw_idx_reg == `PMS_IDX_MASK && wstrb_reg[0])
      mask_next = wdata_reg[1:0];
    if (wr_stat && wstrb_reg[1])
      clr_next = wdata_reg[`PMS_STAT_CLR];
    if (wr_stat && wstrb_reg[0])
      w1c = {wdata_reg[`PMS_STAT_SERR], wdata_reg[`PMS_STAT_DERR]};
    // a new error in the clearing cycle stays set
    err_next    = {sync_timing_err, data_timing_err} | (err_reg & ~w1c);
    irq_oe_next = |(err_reg & ~mask_reg);
  end

  // register file flip-flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg   <= `PMS_CTRL_RST;
      cfg_reg    <= `PMS_CFG_RST;
      clr_reg    <= 1'h0;
      mask_reg   <= 2'h0;
      err_reg    <= 2'h0;
      irq_oe_reg <= 1'h0;
    end else begin
      ctrl_reg   <= ctrl_next;
      cfg_reg    <= cfg_next;
      clr_reg    <= clr_next;
      mask_reg   <= mask_next;
      err_reg    <= err_next;
      irq_oe_reg <= irq_oe_next;
    end
  end

  // code correlator on the receive window
  pms_correlator u_corr (
    .window (win_reg),
    .thresh (cfg.thresh),
    .hit    (hit)
  );

  // frame transmitter, master only, carrying the local oscillator phase
  pms_pn_tx u_tx (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .en         (tx_on_reg),
    .phase_word (nco_phase_in),
    .code_bit   (tx_bit)
  );

  // receiver: search for the code, then track it once per 64-chip frame
  always_comb begin
    st_next    = st_reg;
    fcnt_next  = fcnt_reg + 6'h01;
    win_next   = rx_act ? {win_reg[30:0], sync_in} : 32'h0;
    lock_next  = lock_reg;
    lost_next  = lost_reg & ~clr_reg;
    align_next = 1'h0;
    load_next  = 1'h0;
    ph_next    = ph_reg;
    tx_on_next = code_mode & cfg.tx_en;
    if (!rx_act) begin
      st_next   = st_search;
      lock_next = 1'h0;
      fcnt_next = 6'h00;
    end else begin
      unique case (st_reg)
        st_search: begin
          if (hit) begin
            align_next = 1'h1;
            lock_next  = 1'h1;
            fcnt_next  = 6'h00;
            st_next    = st_track;
          end
        end
        st_track: begin
          if (fcnt_reg == `PMS_PHASE_LAST) begin
            load_next = 1'h1;
            ph_next   = win_reg;
          end
          if (fcnt_reg == `PMS_FRAME_LAST) begin
            if (hit) begin
              align_next = 1'h1;
              fcnt_next  = 6'h00;
            end else begin
              lock_next = 1'h0;
              lost_next = 1'h1;
              st_next   = st_search;
            end
          end
        end
      endcase
    end
    // the state machine free-runs over 32 states, reloaded by each pulse
    csm_next = align_next ? {1'h0, cfg.clk_state} : csm_reg + 5'h01;
  end

  // receiver and clock state machine flip-flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg    <= st_search;
      fcnt_reg  <= 6'h00;
      win_reg   <= 32'h0;
      lock_reg  <= 1'h0;
      lost_reg  <= 1'h0;
      align_reg <= 1'h0;
      load_reg  <= 1'h0;
      ph_reg    <= 32'h0;
      csm_reg   <= 5'h00;
      tx_on_reg <= 1'h0;
    end else begin
      st_reg    <= st_next;
      fcnt_reg  <= fcnt_next;
      win_reg   <= win_next;
      lock_reg  <= lock_next;
      lost_reg  <= lost_next;
      align_reg <= align_next;
      load_reg  <= load_next;
      ph_reg    <= ph_next;
      csm_reg   <= csm_next;
      tx_on_reg <= tx_on_next;
    end
  end

  // port drive
  assign s_axi_awready = ~aw_hold_reg;
  assign s_axi_wready  = ~w_hold_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign sync_out      = tx_bit;
  assign sync_out_oe   = tx_on_reg;
  assign sync_out_dly  = cfg.out_dly;
  assign sync_out_half = cfg.out_half;
  assign sync_in_dly   = cfg.in_dly;
  assign nco_phase_out = ph_reg;
  assign nco_load      = load_reg;
  assign align_pulse   = align_reg;
  assign clk_gen_state = csm_reg;
  assign sync_lock     = lock_reg;
  assign irq_out       = 1'h0;
  assign irq_oe        = irq_oe_reg;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_lock_on_hit: assert property (rx_act && st_reg == st_search && hit |=> lock_reg && align_reg)
    else $error("code seen but no lock or pulse");
  a_csm_load: assert property (align_reg |-> csm_reg == {1'h0, $past(cfg.clk_state)})
    else $error("pulse did not load clock state");
  a_csm_count: assert property ($past(rst_b) && !align_reg
                                |-> csm_reg == $past(csm_reg) + 5'h01)
    else $error("clock state did not step");
  a_lost_on_miss: assert property (rx_act && st_reg == st_track &&
                                   fcnt_reg == 6'h3F && !hit |=> lost_reg && !lock_reg)
    else $error("missed code not flagged");
  a_lost_sticky: assert property (lost_reg && !clr_reg |=> lost_reg)
    else $error("lost bit dropped without clear");
  a_align_frame: assert property (align_reg && $past(st_reg) == st_track
                                  |-> $past(fcnt_reg) == 6'h3F)
    else $error("pulse outside expected code slot");
  a_irq_pending: assert property (|(err_reg & ~mask_reg) |=> irq_oe && !irq_out)
    else $error("unmasked flag did not pull interrupt");
  a_flag_masked: assert property (data_timing_err && mask_reg[0] |=> err_reg[0]
                                  ##1 !irq_oe || err_reg[1] || !mask_reg[0])
    else $error("masked flag lost or raised interrupt");
  a_flag_hold: assert property (err_reg[1] &&
                                !(do_wr && aw_idx_reg == `PMS_IDX_STAT) |=> err_reg[1])
    else $error("sync error flag dropped unwritten");
  a_tx_master: assert property (sync_out_oe |-> $past(cfg.tx_en && code_mode))
    else $error("sync output driven without enable");
  a_phase_load: assert property (nco_load |-> nco_phase_out == $past(win_reg))
    else $error("phase load not from frame");

  c_lock: cover property (rx_act ##1 lock_reg);
  c_lost: cover property ($rose(lost_reg));
  c_reload: cover property (align_reg ##64 align_reg);
  c_irq: cover property ($rose(irq_oe));
endmodule
`default_nettype wire

/* File: bench/pms_far_master.sv */
/*
  far-side master device model: sends code frames onto the sync line.
  assumes the bench holds phase steady and changes flip between frames.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pms_defs.svh"
module pms_far_master import pms_pkg::*; (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        run,
  input  wire logic [5:0]  flip,
  input  wire logic [31:0] phase,
  output logic             chip
);
  logic [5:0]  cnt_reg;
  logic [63:0] frm;
  // 32 code chips then 32 phase bits, msb first
  assign frm = {`PMS_PN_WORD, phase};
  // frame counter; flip corrupts the first code chips of each frame
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 6'h00;
      chip    <= 1'b0;
    end else if (run) begin
      cnt_reg <= cnt_reg + 6'h01;
      chip    <= frm[6'h3F - cnt_reg] ^ (cnt_reg < flip);
    end else begin
      chip    <= ~chip; // idle line has no pull, keep it moving
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
/*
  self-checking bench of the sync engine with a register model.
  assumes the far master model beside it and the design files under rtl.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pms_defs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
`define WAIT(c, lim) for (n = 0; n < lim && !(c); n++) @(posedge clk_sys);
module tb_top import pms_pkg::*;;
  logic        clk_sys = 1'b0, rst_b = 1'b0, run = 1'b0, sync_in;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, nco_phase_in = 32'h0, s_axi_rdata, nco_phase_out, d, sh;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        data_timing_err = 1'b0, sync_timing_err = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        sync_out, sync_out_oe, sync_out_half, nco_load, align_pulse, sync_lock;
  logic        irq_out, irq_oe;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0]  sync_out_dly, sync_in_dly, clk_gen_state;
  logic [5:0]  flip = 6'h00;
  logic [31:0] seed = 32'h0000_B9C4;
  logic [31:0] mdl [logic [7:0]];
  int          fail_count = 0, compares = 0, n;

  pms_sync_top i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sync_in(sync_in), .sync_out(sync_out),
    .sync_out_oe(sync_out_oe), .sync_out_dly(sync_out_dly), .sync_out_half(sync_out_half),
    .sync_in_dly(sync_in_dly), .nco_phase_in(nco_phase_in), .nco_phase_out(nco_phase_out),
    .nco_load(nco_load), .align_pulse(align_pulse), .clk_gen_state(clk_gen_state),
    .sync_lock(sync_lock), .data_timing_err(data_timing_err),
    .sync_timing_err(sync_timing_err), .irq_out(irq_out), .irq_oe(irq_oe));
  pms_far_master i_far (.clk_sys(clk_sys), .rst_b(rst_b), .run(run), .flip(flip),
    .phase(nco_phase_in), .chip(sync_in));

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  // xorshift generator
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // writable bits of each modelled register
  function automatic logic [31:0] wm(input logic [7:0] idx);
    return idx == `PMS_IDX_CTRL ? `PMS_CTRL_WMASK : idx == `PMS_IDX_CFG ? `PMS_CFG_WMASK : 32'h3;
  endfunction
  // axi write: address and data offered together, response awaited; model follows byte lanes
  task automatic wr(input logic [7:0] idx, input logic [31:0] v);
    logic [31:0] lm;
    @(posedge clk_sys);
    lm = wm(idx) & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    s_axi_awaddr  <= {2'h0, idx, 2'h0};
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    `CHK(s_axi_bvalid, 1'b1)
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (mdl.exists(idx)) mdl[idx] = (v & lm) | (mdl[idx] & ~lm);
  endtask
  // axi read
  task automatic rd(input logic [7:0] idx, output logic [31:0] v);
    @(posedge clk_sys);
    s_axi_araddr  <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    `CHK(s_axi_rvalid, 1'b1)
    v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // one-cycle pulse on a timing error input, then let the flag settle
  task automatic err(input int i);
    @(posedge clk_sys);
    {sync_timing_err, data_timing_err} <= 2'b01 << i;
    @(posedge clk_sys);
    {sync_timing_err, data_timing_err} <= 2'b00;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask
  task automatic print_verdict;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog, far beyond the thousand or so cycles the tests need
  initial begin
    #200000;
    fail_count++;
    print_verdict;
  end

  // main sequence
  initial begin
    mdl[`PMS_IDX_CTRL] = `PMS_CTRL_RST;
    mdl[`PMS_IDX_CFG]  = `PMS_CFG_RST;
    mdl[`PMS_IDX_MASK] = 32'h0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (mdl[i]) begin
      rd(i, d);
      `CHK(d, mdl[i])
    end
    rd(`PMS_IDX_STAT, d);
    `CHK(d, 32'h0)
    rd(8'hFF, d);
    `CHK({rsp, d}, {`PMS_RESP_SLVERR, 32'h0})
    wr(8'hFF, 32'hFFFF_FFFF);
    `CHK(rsp, `PMS_RESP_SLVERR)
    fin("reset");
    // random configuration reaches the delay pins
    seed = xs(seed);
    wr(`PMS_IDX_CFG, seed);
    rd(`PMS_IDX_CFG, d);
    `CHK(d, mdl[`PMS_IDX_CFG])
    `CHK(sync_in_dly, mdl[`PMS_IDX_CFG][23:19])
    `CHK(sync_out_dly, mdl[`PMS_IDX_CFG][15:11])
    `CHK(sync_out_half, mdl[`PMS_IDX_CFG][9])
    // one byte lane only: the output delay byte is cleared, the rest kept
    s_axi_wstrb <= 4'h2;
    wr(`PMS_IDX_CFG, 32'h0);
    s_axi_wstrb <= 4'hF;
    rd(`PMS_IDX_CFG, d);
    `CHK(d, mdl[`PMS_IDX_CFG])
    fin("config");
    // slave lock, clock state and phase load
    seed = xs(seed);
    nco_phase_in <= seed;
    wr(`PMS_IDX_CFG, 32'h8400_0050);
    wr(`PMS_IDX_CTRL, 32'h0000_3800);
    run <= 1'b1;
    repeat (200) @(posedge clk_sys);
    `CHK(sync_lock, 1'b0)
    wr(`PMS_IDX_CTRL, 32'h0000_3000);
    `WAIT(align_pulse, 300)
    `CHK(align_pulse, 1'b1)
    `CHK(clk_gen_state, 5'h05)
    @(posedge clk_sys);
    `WAIT(align_pulse, 100)
    `CHK(n, 63)
    `CHK(clk_gen_state, 5'h05)
    `WAIT(nco_load, 100)
    `CHK(nco_load, 1'b1)
    `CHK(nco_phase_out, nco_phase_in)
    rd(`PMS_IDX_STAT, d);
    `CHK(d[11:10], 2'b01)
    fin("lock");
    // corrupted chips at the threshold boundary, loss and clearing
    `WAIT(align_pulse, 100)
    flip <= 6'h08;
    repeat (140) @(posedge clk_sys);
    `CHK(sync_lock, 1'b1)
    flip <= 6'h09;
    `WAIT(!sync_lock, 140)
    `CHK(sync_lock, 1'b0)
    rd(`PMS_IDX_STAT, d);
    `CHK(d[11:10], 2'b10)
    flip <= 6'h00;
    `WAIT(sync_lock, 300)
    `CHK(sync_lock, 1'b1)
    wr(`PMS_IDX_STAT, 32'h0000_1000);
    wr(`PMS_IDX_STAT, 32'h0);
    rd(`PMS_IDX_STAT, d);
    `CHK(d[11:10], 2'b01)
    fin("loss");
    // master transmit, then receive and transmit disabled
    wr(`PMS_IDX_CFG, 32'h8600_0050);
    sh = 32'h0;
    for (n = 0; n < 200 && sh !== `PMS_PN_WORD; n++) begin
      @(posedge clk_sys);
      sh = {sh[30:0], sync_out};
    end
    `CHK(sh, `PMS_PN_WORD)
    `CHK(sync_out_oe, 1'b1)
    wr(`PMS_IDX_CFG, 32'h8000_0050);
    repeat (3) @(posedge clk_sys);
    `CHK({sync_out_oe, sync_lock}, 2'b00)
    fin("master");
    // error flags: raise, clear, mask
    for (int i = 0; i < 2; i++) begin
      err(i);
      `CHK({irq_oe, irq_out}, 2'b10)
      rd(`PMS_IDX_STAT, d);
      `CHK(d[5 + i], 1'b1)
      wr(`PMS_IDX_STAT, 32'h20 << i);
      repeat (2) @(posedge clk_sys);
      `CHK(irq_oe, 1'b0)
      wr(`PMS_IDX_MASK, 32'h1 << i);
      err(i);
      `CHK(irq_oe, 1'b0)
      rd(`PMS_IDX_STAT, d);
      `CHK(d[5 + i], 1'b1)
      wr(`PMS_IDX_STAT, 32'h20 << i);
      rd(`PMS_IDX_MASK, d);
      `CHK(d, mdl[`PMS_IDX_MASK])
      wr(`PMS_IDX_MASK, 32'h0);
    end
    fin("irq");
    print_verdict;
  end
endmodule
`default_nettype wire
